// ### bsm_pkg.sv
// Shared constants and state type of the buffered serial sequence master
`default_nettype none
package bsm_pkg;
    // Timing sources and serial bit rate
    localparam int unsigned OSC_KHZ       = 12000;    // Internal oscillator, 12.0 MHz
    localparam int unsigned PLL_MHZ       = 156;      // On-chip PLL output
    localparam int unsigned CORE_HZ       = 25000000; // Core clock of this block
    localparam int unsigned SCL_HZ        = 1000000;  // Serial bit rate
    localparam int unsigned QTR_CYC       = (CORE_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

    // Sizes
    localparam int unsigned BUF_BYTES     = 4352;
    localparam int unsigned SLOTS         = 64;
    localparam int unsigned BAW           = 13;
    // Register byte addresses
    localparam logic [11:0] A_CONTROL     = 12'h000;
    localparam logic [11:0] A_CH_STATUS   = 12'h004;
    localparam logic [11:0] A_NACK_MASK   = 12'h008;
    localparam logic [11:0] A_SLAVE_TABLE = 12'h00C;
    localparam logic [11:0] A_TRAN_COUNT  = 12'h010;
    localparam logic [11:0] A_TRAN_CONFIG = 12'h014;
    localparam logic [11:0] A_DATA        = 12'h018;
    localparam logic [11:0] A_SLOT_SEL    = 12'h01C;
    localparam logic [11:0] A_BYTE_OFS    = 12'h020;
    localparam logic [11:0] A_CTRL_STATUS = 12'h024;
    localparam logic [11:0] A_CTRL_MASK   = 12'h028;
    localparam logic [3:0]  A_STAT_PAGE   = 4'h1;     // 0x100 + 4*n

    // Field positions
    localparam int unsigned F_START       = 0;
    localparam int unsigned F_CH_RESET    = 1;
    localparam int unsigned F_WR_MASK     = 0;
    localparam int unsigned F_RD_MASK     = 1;
    localparam int unsigned F_OVF         = 0;
    localparam int unsigned F_CHERR_MASK  = 1;

    // Transaction status codes
    localparam logic [7:0] ST_DONE        = 8'h01;
    localparam logic [7:0] ST_ADDR_NACK   = 8'h02;
    localparam logic [7:0] ST_DATA_NACK   = 8'h04;
    localparam logic [7:0] ST_ABORTED     = 8'h08;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_START = 6'b000010,
        S_ADDR  = 6'b000100,
        S_TX    = 6'b001000,
        S_RX    = 6'b010000,
        S_STOP  = 6'b100000
    } bsm_state_t;

    typedef struct packed {
        bsm_state_t       st;
        logic [7:0]       div;
        logic [1:0]       ph;
        logic [3:0]       bitn;
        logic [7:0]       sh;
        logic             rx;
        logic             nack;
        logic [5:0]       slot;
        logic [BAW-1:0]   left;
        logic [BAW-1:0]   bptr;
        logic [BAW-1:0]   hptr;
        logic [6:0]       cfg_ptr;
        logic [6:0]       sla_ptr;
        logic [6:0]       tcount;
        logic [5:0]       sel;
        logic [7:0]       ofs;
        logic             busy;
        logic             done;
        logic             cherr;
        logic             ovf;
        logic             wmsk;
        logic             rmsk;
        logic             bmsk;
        logic             cmsk;
        logic [SLOTS-1:0] svalid;
        logic             rdy;
        logic             slverr;
        logic [31:0]      rdata;
        logic             scl_s1;
        logic             scl_s2;
        logic             sda_s1;
        logic             sda_s2;
        logic             scl_oe;
        logic             sda_oe;
        logic             int_oe;
        logic             pin_lvl;
    } bsm_regs_t;
endpackage
`default_nettype wire

// ### bsm_slave.sv
// Behavioural serial slave: one acked address, fixed read byte
`timescale 1ns/1ps
`default_nettype none
module bsm_slave
#(
    parameter logic [6:0] ADR  = 7'h2A,
    parameter logic [7:0] RDAT = 8'hC3,
    parameter int         STR  = 0
)
(
    input  wire logic scl,  // Wire level
    input  wire logic sda,  // Wire level
    output logic      pull, // Data low
    output logic      hold  // Clock low
);
    logic [3:0] n = 0;
    logic [7:0] sh = 0;
    logic act = 0, rd = 0, first = 0, nk = 0;
    initial {pull, hold} = 2'b00;
    always @(negedge sda) if (scl) {n, first, act, pull} = {4'h0, 3'b100};
    always @(posedge sda) if (scl) {act, pull} = 2'b00;
    always @(posedge scl)
    begin
        if (n < 8) sh = {sh[6:0], sda};
        if (n == 8) nk = sda;
        n = n + 1;
    end
    // Slow answer: hold the clock low a while
    always @(negedge scl) if (STR > 0)
    begin
        hold = 1;
        #(STR) hold = 0;
    end
    always @(negedge scl)
    begin
        if (n == 9 && rd && nk) act = 0;
        if (n == 9) n = 0;
        pull = 0;
        if (n == 8 && first)
        begin
            act = sh[7:1] == ADR;
            rd = sh[0];
            first = 0;
            pull = act;
        end
        else if (n == 8) pull = act && !rd;
        else if (n < 8 && act && rd) pull = !RDAT[7 - n];
    end
endmodule
`default_nettype wire

// ### bsm_top.sv
// Single-channel buffered serial sequence master with APB register access
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - All serial timing derives from oscillator and PLL rates, here the core clock.
// - Timing divider keeps running while the serial bus is idle.
// - Channel owns a private 4352-byte data buffer.
// - Slot select and byte offset reset to zero; host zeroes them before loading.
// - Data write beyond the buffer sets the overflow flag.
// - Overflow pulls interrupt low only while its mask bit is zero.
// - Transmission starts only after a write to the control register.
// - Transactions go in table order, repeated start between, stop at end.
// - Read with address NACK leaves its reserved buffer bytes untouched.
// - Host writes into an idle channel buffer are accepted anytime.
// - Master NACKs the last byte it reads from a slave.
// - Buffer holds only payload; addresses and config stored apart.
// - Errors logged per transaction, in channel and controller status, with interrupt; controller status holds only the overflow flag.
// - Unmasked NACK raises interrupt and aborts the rest of the sequence.
// - Masked NACK is logged, failing transaction skipped, sequence continues.
// - Reads and writes to different slaves mix freely in one sequence.
// - One read-only, directly addressed status entry per slot, 64 entries.
// - Interrupt output is active low open-drain.
module bsm_top
    import bsm_pkg::*;
(
    input  wire logic        I_CORE_CLK,   // Core clock
    input  wire logic        I_RST_N,      // Async reset, active low
    input  wire logic        I_PSEL,       // APB select
    input  wire logic        I_PENABLE,    // APB enable
    input  wire logic        I_PWRITE,     // APB direction
    input  wire logic [11:0] I_PADDR,      // APB byte address
    input  wire logic [31:0] I_PWDATA,     // APB write data
    output logic      [31:0] O_PRDATA,     // APB read data
    output logic             O_PREADY,     // APB ready
    output logic             O_PSLVERR,    // APB error, unmapped address
    input  wire logic        I_SCL_IN,     // Serial clock level
    output logic             O_SCL_OUT,    // Serial clock drive level, always low
    output logic             O_SCL_OE,     // Serial clock pulled low
    input  wire logic        I_SDA_IN,     // Serial data level
    output logic             O_SDA_OUT,    // Serial data drive level, always low
    output logic             O_SDA_OE,     // Serial data pulled low
    output logic             O_INT_N_OUT,  // Interrupt drive level, always low
    output logic             O_INT_N_OE    // Interrupt pulled low
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage kept apart from the control state

    logic [7:0]     buf_mem  [BUF_BYTES];
    logic [7:0]     sla_mem  [SLOTS];
    logic [BAW-1:0] cnt_mem  [SLOTS];
    logic [BAW-1:0] end_mem  [SLOTS];
    logic [7:0]     stat_mem [SLOTS];

    bsm_regs_t      r;
    bsm_regs_t      n;

    logic           buf_we;
    logic [BAW-1:0] buf_wa;
    logic [7:0]     buf_wd;
    logic           sla_we;
    logic           cfg_we;
    logic [BAW-1:0] cfg_end;
    logic           stat_we;
    logic [7:0]     stat_wd;
    logic           acc;
    logic           take;
    logic           wr;
    logic [31:0]    wd;
    logic           fin;
    logic           abort;
    logic [7:0]     fcode;
    logic [BAW-1:0] nb;

    function automatic logic [BAW-1:0] slot_base(input logic [6:0] k);
        slot_base = (k == 7'h00) ? '0 : end_mem[6'(k - 7'h01)];
    endfunction

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[11:8] == A_STAT_PAGE) && (a[1:0] == 2'h0);
        if (a == A_CONTROL || a == A_CH_STATUS || a == A_NACK_MASK || a == A_SLAVE_TABLE
            || a == A_TRAN_COUNT || a == A_TRAN_CONFIG || a == A_DATA || a == A_SLOT_SEL
            || a == A_BYTE_OFS || a == A_CTRL_STATUS || a == A_CTRL_MASK)
            mapped = 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        n       = r;
        buf_we  = 1'b0;
        buf_wa  = r.hptr;
        buf_wd  = I_PWDATA[7:0];
        sla_we  = 1'b0;
        cfg_we  = 1'b0;
        cfg_end = slot_base(r.cfg_ptr) + I_PWDATA[BAW-1:0];
        stat_we = 1'b0;
        stat_wd = ST_DONE;
        fin     = 1'b0;
        abort   = 1'b0;
        fcode   = ST_DONE;
        nb      = r.bptr + 13'h0001;
        acc     = I_PSEL & I_PENABLE;
        take    = acc & r.rdy;
        wr      = take & I_PWRITE;
        wd      = I_PWDATA;

        // Two-stage synchronisers
        n.scl_s1 = I_SCL_IN;
        n.scl_s2 = r.scl_s1;
        n.sda_s1 = I_SDA_IN;
        n.sda_s2 = r.sda_s1;

        // One wait state so read data comes from a flop
        n.rdy    = acc & ~r.rdy;
        n.slverr = acc & ~r.rdy & ~mapped(I_PADDR);
        if (acc && !r.rdy)
        begin
            n.rdata  = 32'h0000_0000;
            case (I_PADDR)
                A_CONTROL:     n.rdata[F_START] = r.busy;
                A_CH_STATUS:   n.rdata = {29'h0, r.cherr, r.done, r.busy};
                A_NACK_MASK:   n.rdata = {30'h0, r.rmsk, r.wmsk};
                A_TRAN_COUNT:  n.rdata = {25'h0, r.tcount};
                A_DATA:        n.rdata = (r.hptr < BAW'(BUF_BYTES))
                                         ? {24'h0, buf_mem[r.hptr]} : 32'h0000_0000;
                A_SLOT_SEL:    n.rdata = {26'h0, r.sel};
                A_BYTE_OFS:    n.rdata = {24'h0, r.ofs};
                A_CTRL_STATUS: n.rdata = {31'h0, r.ovf};
                A_CTRL_MASK:   n.rdata = {30'h0, r.cmsk, r.bmsk};
                default:
                begin
                    if (I_PADDR[11:8] == A_STAT_PAGE && r.svalid[I_PADDR[7:2]])
                        n.rdata = {24'h0, stat_mem[I_PADDR[7:2]]};
                end
            endcase
        end

        // Data port reads advance the pointer as well
        if (take && !I_PWRITE && I_PADDR == A_DATA)
            n.hptr = r.hptr + 13'h0001;

        if (wr)
        begin
            case (I_PADDR)
                A_CONTROL:
                begin
                    if (wd[F_START] && !r.busy && r.tcount != 7'h00)
                    begin
                        n.busy   = 1'b1;
                        n.done   = 1'b0;
                        n.cherr  = 1'b0;
                        n.svalid = '0;
                        n.slot   = 6'h00;
                        n.bptr   = '0;
                        n.st     = S_START;
                        n.ph     = 2'h0;
                    end
                end
                A_NACK_MASK:
                begin
                    n.wmsk = wd[F_WR_MASK];
                    n.rmsk = wd[F_RD_MASK];
                end
                A_SLAVE_TABLE:
                begin
                    if (!r.busy && r.sla_ptr < 7'(SLOTS))
                    begin
                        sla_we    = 1'b1;
                        n.sla_ptr = r.sla_ptr + 7'h01;
                    end
                end
                A_TRAN_COUNT:
                begin
                    if (!r.busy && wd[6:0] <= 7'(SLOTS))
                    begin
                        n.tcount  = wd[6:0];
                        n.cfg_ptr = 7'h00;
                    end
                end
                A_TRAN_CONFIG:
                begin
                    if (!r.busy && r.cfg_ptr < 7'(SLOTS))
                    begin
                        cfg_we    = 1'b1;
                        n.cfg_ptr = r.cfg_ptr + 7'h01;
                    end
                end
                A_DATA:
                begin
                    n.hptr = r.hptr + 13'h0001;
                    if (r.hptr >= BAW'(BUF_BYTES))
                        n.ovf = 1'b1;
                    else
                        buf_we = 1'b1;
                end
                A_SLOT_SEL:
                begin
                    n.sel  = wd[5:0];
                    n.hptr = slot_base({1'b0, wd[5:0]}) + BAW'(r.ofs);
                end
                A_BYTE_OFS:
                begin
                    n.ofs  = wd[7:0];
                    n.hptr = slot_base({1'b0, r.sel}) + BAW'(wd[7:0]);
                end
                A_CTRL_STATUS:
                begin
                    if (wd[F_OVF])
                        n.ovf = 1'b0;
                end
                A_CTRL_MASK:
                begin
                    n.bmsk = wd[F_OVF];
                    n.cmsk = wd[F_CHERR_MASK];
                end
                default:
                begin
                end
            endcase
        end

        // Overflow set wins over its clear in the same cycle
        if (wr && I_PADDR == A_DATA && r.hptr >= BAW'(BUF_BYTES))
            n.ovf = 1'b1;

        ////////////////////////////////////////////////////////////////////////
        // Quarter-bit divider, never gated so rate stays fixed

        n.div = (r.div == 8'(QTR_CYC - 1)) ? 8'h00 : r.div + 8'h01;

        if (r.busy && r.div == 8'(QTR_CYC - 1))
        begin
            n.ph = r.ph + 2'h1;
            case (r.st)
                S_START:
                begin
                    // Same pattern serves first start and repeated start
                    case (r.ph)
                        2'h0: n.sda_oe = 1'b0;
                        2'h1:
                        begin
                            n.scl_oe = 1'b0;
                            if (!r.scl_s2)
                                n.ph = r.ph;
                        end
                        2'h2: n.sda_oe = 1'b1;
                        default:
                        begin
                            n.scl_oe = 1'b1;
                            n.st     = S_ADDR;
                            n.bitn   = 4'h0;
                            n.sh     = sla_mem[r.slot];
                            n.rx     = sla_mem[r.slot][0];
                        end
                    endcase
                end
                S_ADDR, S_TX, S_RX:
                begin
                    case (r.ph)
                        2'h0:
                        begin
                            if (r.bitn != 4'h8)
                                n.sda_oe = (r.st == S_RX) ? 1'b0 : ~r.sh[7];
                            else if (r.st == S_RX)
                                n.sda_oe = (r.left != 13'h0001);
                            else
                                n.sda_oe = 1'b0;
                        end
                        2'h1:
                        begin
                            n.scl_oe = 1'b0;
                            if (!r.scl_s2)
                                n.ph = r.ph;  // Slave clock stretching
                        end
                        2'h2:
                        begin
                            if (r.bitn != 4'h8)
                                n.sh = {r.sh[6:0], (r.st == S_RX) ? r.sda_s2 : 1'b0};
                            else
                                n.nack = r.sda_s2;
                        end
                        default:
                        begin
                            n.scl_oe = 1'b1;
                            n.bitn   = r.bitn + 4'h1;
                            if (r.bitn == 4'h8)
                            begin
                                n.bitn = 4'h0;
                                if (r.st == S_ADDR)
                                begin
                                    n.left = cnt_mem[r.slot];
                                    if (r.nack)
                                    begin
                                        fin   = 1'b1;
                                        fcode = ST_ADDR_NACK;
                                        abort = ~(r.rx ? r.rmsk : r.wmsk);
                                    end
                                    else if (cnt_mem[r.slot] == '0)
                                        fin = 1'b1;
                                    else
                                    begin
                                        n.st = r.rx ? S_RX : S_TX;
                                        n.sh = buf_mem[r.bptr];
                                    end
                                end
                                else
                                begin
                                    n.bptr = nb;
                                    n.left = r.left - 13'h0001;
                                    n.sh   = buf_mem[nb];
                                    if (r.st == S_RX)
                                    begin
                                        buf_we = 1'b1;
                                        buf_wa = r.bptr;
                                        buf_wd = r.sh;
                                    end
                                    if (r.st == S_TX && r.nack)
                                    begin
                                        fin   = 1'b1;
                                        fcode = ST_DATA_NACK;
                                        abort = ~r.wmsk;
                                    end
                                    else if (r.left == 13'h0001)
                                        fin = 1'b1;
                                end
                            end
                        end
                    endcase
                end
                S_STOP:
                begin
                    case (r.ph)
                        2'h0: n.sda_oe = 1'b1;
                        2'h1:
                        begin
                            n.scl_oe = 1'b0;
                            if (!r.scl_s2)
                                n.ph = r.ph;
                        end
                        2'h2: n.sda_oe = 1'b0;
                        default:
                        begin
                            n.st   = S_IDLE;
                            n.busy = 1'b0;
                            n.done = 1'b1;
                        end
                    endcase
                end
                default:
                begin
                    n.st   = S_IDLE;
                    n.busy = 1'b0;
                end
            endcase
        end

        // End of one transaction
        if (fin)
        begin
            stat_we           = 1'b1;
            stat_wd           = abort ? (fcode | ST_ABORTED) : fcode;
            n.svalid[r.slot]  = 1'b1;
            if (fcode != ST_DONE)
                n.cherr = 1'b1;
            if (abort || 7'(r.slot) + 7'h01 == r.tcount)
                n.st = S_STOP;
            else
            begin
                n.st   = S_START;
                n.slot = r.slot + 6'h01;
                n.bptr = end_mem[r.slot];  // Skips untouched read bytes
            end
        end

        // Channel reset
        if (wr && I_PADDR == A_CONTROL && wd[F_CH_RESET])
        begin
            n.st      = S_IDLE;
            n.busy    = 1'b0;
            n.done    = 1'b0;
            n.cherr   = 1'b0;
            n.svalid  = '0;
            n.sel     = 6'h00;
            n.ofs     = 8'h00;
            n.hptr    = '0;
            n.cfg_ptr = 7'h00;
            n.sla_ptr = 7'h00;
            n.tcount  = 7'h00;
            n.scl_oe  = 1'b0;
            n.sda_oe  = 1'b0;
            buf_we    = 1'b0;
        end

        n.int_oe = (r.ovf & ~r.bmsk) | (r.cherr & ~r.cmsk);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            r        <= '0;
            r.st     <= S_IDLE;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
        end
        else
            r <= n;
    end

    // Memories hold no reset; their validity is tracked by pointers and flags
    always_ff @(posedge I_CORE_CLK)
    begin
        if (buf_we)
            buf_mem[buf_wa] <= buf_wd;
        if (sla_we)
            sla_mem[6'(r.sla_ptr)] <= I_PWDATA[7:0];
        if (cfg_we)
        begin
            cnt_mem[6'(r.cfg_ptr)] <= I_PWDATA[BAW-1:0];
            end_mem[6'(r.cfg_ptr)] <= cfg_end;
        end
        if (stat_we)
            stat_mem[r.slot] <= stat_wd;
    end

    assign O_PRDATA    = r.rdata;
    assign O_PREADY    = r.rdy;
    assign O_PSLVERR   = r.slverr;
    assign O_SCL_OUT   = r.pin_lvl;
    assign O_SCL_OE    = r.scl_oe;
    assign O_SDA_OUT   = r.pin_lvl;
    assign O_SDA_OE    = r.sda_oe;
    assign O_INT_N_OUT = r.pin_lvl;
    assign O_INT_N_OE  = r.int_oe;

endmodule

`default_nettype wire

// ### bsm_top_properties.sv
// Port-level checks of the sequence master
`timescale 1ns/1ps
`default_nettype none
module bsm_props
    import bsm_pkg::*;
(
    input  wire logic        I_CORE_CLK,  // Clock
    input  wire logic        I_RST_N,     // Reset
    input  wire logic        I_PSEL,      // Select
    input  wire logic        I_PENABLE,   // Enable
    input  wire logic        I_PWRITE,    // Direction
    input  wire logic [11:0] I_PADDR,     // Address
    input  wire logic [31:0] I_PWDATA,    // Write data
    input  wire logic        O_PREADY,    // Ready
    input  wire logic        O_PSLVERR,   // Error
    input  wire logic        O_SCL_OUT,   // Clock level
    input  wire logic        O_SCL_OE,    // Clock pull
    input  wire logic        O_SDA_OUT,   // Data level
    input  wire logic        O_SDA_OE,    // Data pull
    input  wire logic        O_INT_N_OUT, // Int level
    input  wire logic        O_INT_N_OE   // Int pull
);
    logic go_reg;
    // Set once a start write commits
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N)
        if (!I_RST_N)
            go_reg <= 1'b0;
        else if (I_PSEL && I_PENABLE && O_PREADY && I_PWRITE
                 && I_PADDR == A_CONTROL && I_PWDATA[F_START])
            go_reg <= 1'b1;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    a_ready_one_wait: assert property ($rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 O_PREADY)
        else $error("ready not after one wait");
    a_ready_one_cycle: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready held");
    a_quiet_before_go: assert property (!go_reg |-> !O_SCL_OE && !O_SDA_OE)
        else $error("bus driven before start");
    a_status_mapped: assert property (I_PSEL && O_PREADY && I_PADDR[11:8] == A_STAT_PAGE
        && I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR) else $error("status entry refused");
    a_sda_apart_scl: assert property ($changed(O_SCL_OE) |-> $stable(O_SDA_OE))
        else $error("data and clock moved together");
    a_quarter_hold: assert property ($changed(O_SCL_OE) |=> $stable(O_SCL_OE) [*8])
        else $error("clock phase too short");
    a_pins_low: assert property (!O_INT_N_OUT && !O_SCL_OUT && !O_SDA_OUT)
        else $error("open drain level high");
    a_wake_quiet: assert property ($rose(I_RST_N) |-> !O_INT_N_OE && !O_SCL_OE && !O_PREADY)
        else $error("outputs active after reset");
    c_run: cover property (go_reg && O_SDA_OE);
    c_irq: cover property (O_INT_N_OE);
    c_err: cover property (O_PSLVERR);
endmodule
bind bsm_top bsm_props u_props (.*);
`default_nettype wire

// ### tb_bsm_top.sv
// Directed bench for the sequence master
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_bsm_top;
    import bsm_pkg::*;
    localparam logic [6:0] ADR = 7'h2A;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, serr;
    logic [11:0] paddr = 0;
    logic [31:0] pwd = 0, rdat, prdata;
    logic        pready, slverr, scl_oe, sda_oe, int_oe, pull, hold;
    int          n_mismatch = 0, comparisons = 0;
    wire logic   scl = !(scl_oe || hold);
    wire logic   sda = !(sda_oe || pull);
    bsm_top uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(slverr), .I_SCL_IN(scl), .O_SCL_OUT(),
        .O_SCL_OE(scl_oe), .I_SDA_IN(sda), .O_SDA_OUT(), .O_SDA_OE(sda_oe),
        .O_INT_N_OUT(), .O_INT_N_OE(int_oe));
    bsm_slave #(.ADR(ADR), .RDAT(8'hC3), .STR(600)) sl (.scl(scl), .sda(sda),
        .pull(pull), .hold(hold));
    initial forever #20 clk = ~clk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, paddr, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rdat, serr} = {prdata, slverr};
        {psel, pen} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdat)
    endtask
    task automatic load(input logic [7:0] cfg[$], sla[$], dat[$]);
        wr(A_CONTROL, 32'h2);
        wr(A_TRAN_COUNT, 32'(cfg.size()));
        foreach (cfg[i]) wr(A_TRAN_CONFIG, {24'h0, cfg[i]});
        foreach (sla[i]) wr(A_SLAVE_TABLE, {24'h0, sla[i]});
        wr(A_SLOT_SEL, 32'h0);
        wr(A_BYTE_OFS, 32'h0);
        foreach (dat[i]) wr(A_DATA, {24'h0, dat[i]});
        `CHK("idle_scl", 1'b0, scl_oe)
    endtask
    task automatic go_wait;
        wr(A_CONTROL, 32'h1);
        do apb(1'b0, A_CH_STATUS, 32'h0); while (rdat[1] !== 1'b1);
    endtask
    task automatic t_reset;
        chk(A_SLOT_SEL, 32'h0, "slot_sel");
        chk(A_BYTE_OFS, 32'h0, "byte_ofs");
        apb(1'b0, 12'h02C, 32'h0);
        `CHK("unmapped", 1'b1, serr)
    endtask
    task automatic t_mixed;
        wr(A_NACK_MASK, 32'h2);
        load('{8'h2, 8'h2, 8'h1}, '{{ADR, 1'b0}, {ADR, 1'b1}, 8'h23},
            '{8'h12, 8'h34, 8'hFF, 8'hFF, 8'h5C});
        go_wait;
        chk(12'h100, {24'h0, ST_DONE}, "stat0");
        chk(12'h104, {24'h0, ST_DONE}, "stat1");
        chk(12'h108, {24'h0, ST_ADDR_NACK}, "stat2");
        chk(A_CH_STATUS, 32'h6, "ch_status");
        `CHK("int_err", 1'b1, int_oe)
        wr(A_SLOT_SEL, 32'h1);
        wr(A_BYTE_OFS, 32'h0);
        chk(A_DATA, 32'hC3, "rd0");
        chk(A_DATA, 32'hC3, "rd1");
        chk(A_DATA, 32'h5C, "kept");
    endtask
    task automatic t_abort;
        wr(A_NACK_MASK, 32'h0);
        load('{8'h1, 8'h1}, '{8'h22, {ADR, 1'b0}}, '{8'h01, 8'h02});
        go_wait;
        chk(12'h100, {24'h0, ST_ADDR_NACK | ST_ABORTED}, "abort0");
        chk(12'h104, 32'h0, "abort1");
        wr(A_CTRL_MASK, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("int_masked", 1'b0, int_oe)
    endtask
    task automatic t_ovf;
        wr(A_CONTROL, 32'h2);
        wr(A_CTRL_MASK, 32'h3);
        repeat (BUF_BYTES) wr(A_DATA, 32'hA5);
        chk(A_CTRL_STATUS, 32'h0, "no_ovf");
        wr(A_DATA, 32'hA5);
        chk(A_CTRL_STATUS, 32'h1, "ovf");
        `CHK("int_ovf_off", 1'b0, int_oe)
        wr(A_CTRL_MASK, 32'h2);
        repeat (3) @(posedge clk);
        `CHK("int_ovf", 1'b1, int_oe)
        wr(A_CTRL_STATUS, 32'h1);
        chk(A_CTRL_STATUS, 32'h0, "ovf_clr");
    endtask
    task automatic stop_test;
        $display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_mixed;
        t_abort;
        t_ovf;
        stop_test;
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule
`default_nettype wire
